/* design/rtec_pkg.sv */
// Package for the reloadable timer and event counter: map, fields, encodings
package rtec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the plain register port
  localparam logic [3:0] RTEC_ADDR_COUNT  = 4'h0;
  localparam logic [3:0] RTEC_ADDR_MODE   = 4'h1;
  localparam logic [3:0] RTEC_ADDR_START  = 4'h2;
  localparam logic [3:0] RTEC_ADDR_STATUS = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the start and status registers
  localparam int RTEC_START_BIT   = 0;
  localparam int RTEC_STAT_RUN    = 0;
  localparam int RTEC_STAT_OUTLVL = 1;
  localparam int RTEC_STAT_DIRUP  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and prescaler terminal counts
  localparam logic [15:0] RTEC_COUNT_RST = 16'h0000;
  localparam logic [15:0] RTEC_MODE_RST  = 16'h0000;
  localparam logic [15:0] RTEC_ALL_ONES  = 16'hFFFF;
  localparam logic [15:0] RTEC_ZERO      = 16'h0000;
  localparam logic [4:0]  RTEC_PRE_RST   = 5'h00;
  localparam logic [2:0]  RTEC_DIV8_LAST = 3'h7;
  localparam logic [4:0]  RTEC_DIV32_LAST = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  typedef enum logic [1:0] {
    RTEC_OP_TIMER,
    RTEC_OP_EVENT,
    RTEC_OP_ONESHOT,
    RTEC_OP_PWM
  } rtec_op_type;

  typedef enum logic [1:0] {
    RTEC_CLK_UNDIV,
    RTEC_CLK_DIV8,
    RTEC_CLK_DIV32,
    RTEC_CLK_SUB
  } rtec_clk_type;

  typedef enum logic [1:0] {
    RTEC_EV_PIN,
    RTEC_EV_SECOND_ONE,
    RTEC_EV_THIRD_ZERO,
    RTEC_EV_THIRD_TWO
  } rtec_ev_type;

  // Mode register layout, bit 0 at the bottom
  typedef struct packed {
    logic [2:0]   rsvd;
    logic         dir_up;
    logic         dir_from_pin;
    logic         edge_rise;
    rtec_ev_type  ev_src;
    logic         free_run;
    logic         pulse_out;
    logic         gate_high;
    logic         gate_en;
    rtec_clk_type clk_sel;
    rtec_op_type  op_mode;
  } rtec_mode_type;

endpackage

/* design/rtec_timer.sv */
// Reloadable 16-bit timer / event counter with register port and pin logic
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - Timer mode counts down on undivided, div-8, div-32 or sub-clock source.
// - Timer underflow loads reload value and counting carries on.
// - Timer underflow period is set value plus one source periods.
// - Start flag 1 counts, 0 halts, in timer and event modes.
// - Timer underflow raises the interrupt request.
// - Reading the count register returns the live counter value.
// - Write while stopped updates both reload register and counter.
// - Write while counting updates reload only; counter takes it at reload.
// - Gate selected: input pin level starts and stops timer counting.
// - Timer pulse output toggles the output pin on each underflow.
// - Event mode counts chosen pin edges or other timers' overflows.
// - Event direction chosen by software or by output pin as input.
// - Event mode without free-run reloads on overflow or underflow.
// - Event ratio: up 1/(FFFF-n+1), down 1/(n+1).
// - Event overflow or underflow raises the interrupt request.
// - Free-run event mode wraps without reloading.
// - Event pulse output toggles output pin on overflow or underflow.
// - Event output pin is port, pulse output, or direction input.
// - Two lowest mode bits choose timer, event, one-shot or PWM; one-shot and PWM are decoded but never count.
// - Counter and reload register are both 16 bits.

module rtec_timer #(
  parameter int ADDR_W = 4,
  parameter int CNT_W  = 16
) (
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                ce_i,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [CNT_W-1:0]    wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic [CNT_W-1:0]         rdata_o,
  // Count sources
  input  wire logic                sub_clock_divided_source_i,
  input  wire logic                second_group_timer_one_ovf_i,
  input  wire logic                third_group_timer_zero_ovf_i,
  input  wire logic                third_group_timer_two_ovf_i,
  // Pins
  input  wire logic                timer_input_pin_i,
  input  wire logic                timer_output_pin_i,
  output logic                     timer_output_pin_o,
  output logic                     timer_output_pin_oe_o,
  // Interrupt request
  output logic                     irq_o
);
  import rtec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  initial begin
    if (CNT_W != 16) begin
      $error("rtec_timer: CNT_W must be 16 to match the register layout");
    end
    if (ADDR_W < 2) begin
      $error("rtec_timer: ADDR_W must be at least 2");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] reload_r;
  rtec_mode_type    mode_r;
  logic             start_r;
  logic [4:0]       pre_r;
  logic [2:0]       in_sync_r;
  logic [2:0]       sub_sync_r;
  logic [1:0]       dir_sync_r;
  logic             out_lvl_r;
  logic             out_oe_r;
  logic             irq_r;
  logic [CNT_W-1:0] rdata_r;

  logic             in_rise;
  logic             in_fall;
  logic             sub_tick;
  logic             src_tick;
  logic             gate_ok;
  logic             ev_tick;
  logic             tick;
  logic             dir_up;
  logic             wrap;
  logic [CNT_W-1:0] count_nxt;
  logic             is_timer;
  logic             is_event;
  logic             wr_count;

  assign is_timer = (mode_r.op_mode == RTEC_OP_TIMER);
  assign is_event = (mode_r.op_mode == RTEC_OP_EVENT);
  assign wr_count = wr_i && (addr_i == ADDR_W'(RTEC_ADDR_COUNT));

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      in_sync_r  <= 3'h0;
      sub_sync_r <= 3'h0;
      dir_sync_r <= 2'h0;
    end else if (ce_i) begin
      in_sync_r  <= {in_sync_r[1:0], timer_input_pin_i};
      sub_sync_r <= {sub_sync_r[1:0], sub_clock_divided_source_i};
      dir_sync_r <= {dir_sync_r[0], timer_output_pin_i};
    end
  end

  // Edge detect compares stage two with stage three only
  assign in_rise  = in_sync_r[1] && !in_sync_r[2];
  assign in_fall  = !in_sync_r[1] && in_sync_r[2];
  assign sub_tick = sub_sync_r[1] && !sub_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler for the divided internal count clocks
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pre_r <= RTEC_PRE_RST;
    end else if (ce_i) begin
      pre_r <= pre_r + 5'h01;
    end
  end

  // Count source select in timer mode
  always_comb begin
    unique case (mode_r.clk_sel)
      RTEC_CLK_UNDIV: src_tick = 1'b1;
      RTEC_CLK_DIV8:  src_tick = (pre_r[2:0] == RTEC_DIV8_LAST);
      RTEC_CLK_DIV32: src_tick = (pre_r == RTEC_DIV32_LAST);
      RTEC_CLK_SUB:   src_tick = sub_tick;
    endcase
  end

  // Gate level taken from the synchronised input pin
  assign gate_ok = !mode_r.gate_en || (in_sync_r[1] == mode_r.gate_high);

  // Event source select
  always_comb begin
    unique case (mode_r.ev_src)
      RTEC_EV_PIN:        ev_tick = mode_r.edge_rise ? in_rise : in_fall;
      RTEC_EV_SECOND_ONE: ev_tick = second_group_timer_one_ovf_i;
      RTEC_EV_THIRD_ZERO: ev_tick = third_group_timer_zero_ovf_i;
      RTEC_EV_THIRD_TWO:  ev_tick = third_group_timer_two_ovf_i;
    endcase
  end

  // Direction: timer always down, event by software or pin
  assign dir_up = is_event &&
                  (mode_r.dir_from_pin ? dir_sync_r[1] : mode_r.dir_up);

  // One count step; one-shot and PWM are not served here and never tick
  assign tick = start_r && ((is_timer && src_tick && gate_ok) ||
                            (is_event && ev_tick));

  ////////////////////////////////////////////////////////////////////////////
  // Next counter value
  always_comb begin
    wrap      = 1'b0;
    count_nxt = count_r;
    if (dir_up) begin
      if (count_r == RTEC_ALL_ONES) begin
        wrap      = 1'b1;
        // Reload from n gives FFFF-n+1 counts per overflow
        count_nxt = mode_r.free_run ? RTEC_ZERO : reload_r;
      end else begin
        count_nxt = count_r + 16'h0001;
      end
    end else begin
      if (count_r == RTEC_ZERO) begin
        wrap = 1'b1;
        // Reload from n gives n+1 counts per underflow
        if (is_event && mode_r.free_run) begin
          count_nxt = RTEC_ALL_ONES;
        end else begin
          count_nxt = reload_r;
        end
      end else begin
        count_nxt = count_r - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_r <= RTEC_COUNT_RST;
    end else if (ce_i) begin
      if (wr_count && !start_r) begin
        count_r <= wdata_i;
      end else if (tick) begin
        count_r <= count_nxt;
      end
      // Otherwise hold: a stopped counter keeps its value
    end
  end

  // Reload register; written in any state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reload_r <= RTEC_COUNT_RST;
    end else if (ce_i && wr_count) begin
      reload_r <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and start registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_r <= rtec_mode_type'(RTEC_MODE_RST);
    end else if (ce_i && wr_i && (addr_i == ADDR_W'(RTEC_ADDR_MODE))) begin
      mode_r <= rtec_mode_type'(wdata_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      start_r <= 1'b0;
    end else if (ce_i && wr_i && (addr_i == ADDR_W'(RTEC_ADDR_START))) begin
      start_r <= wdata_i[RTEC_START_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin: pulse output or released for port / direction input
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_oe_r <= 1'b0;
    end else if (ce_i) begin
      // Driving in direction mode would fight the external select
      out_oe_r <= mode_r.pulse_out && (is_timer ||
                  (is_event && !mode_r.dir_from_pin));
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_lvl_r <= 1'b0;
    end else if (ce_i && tick && wrap && mode_r.pulse_out) begin
      out_lvl_r <= !out_lvl_r;
    end
  end

  // Interrupt request, one cycle per underflow or overflow
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= tick && wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= RTEC_ZERO;
    end else if (ce_i) begin
      rdata_r <= RTEC_ZERO;
      if (rd_i) begin
        unique case (addr_i)
          ADDR_W'(RTEC_ADDR_COUNT):  rdata_r <= count_r;
          ADDR_W'(RTEC_ADDR_MODE):   rdata_r <= CNT_W'(mode_r);
          ADDR_W'(RTEC_ADDR_START):  rdata_r[RTEC_START_BIT] <= start_r;
          ADDR_W'(RTEC_ADDR_STATUS): begin
            rdata_r[RTEC_STAT_RUN]    <= start_r;
            rdata_r[RTEC_STAT_OUTLVL] <= out_lvl_r;
            rdata_r[RTEC_STAT_DIRUP]  <= dir_up;
          end
          default: rdata_r <= RTEC_ZERO;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign rdata_o               = rdata_r;
  assign irq_o                 = irq_r;
  assign timer_output_pin_o    = out_lvl_r;
  assign timer_output_pin_oe_o = out_oe_r;

endmodule

/* tb/rtec_partner.sv */
// Far side: pulse pin, gate level, sub clock, other timers' overflows
`timescale 1ns/1ps
module rtec_partner (
  // Clock
  input  wire logic                 clk_i,
  // Controls
  input  wire logic [1:0]           pin_mode_i,
  input  wire logic                 ovf_en_i,
  input  wire rtec_pkg::rtec_ev_type ovf_sel_i,
  input  wire logic                 dir_up_i,
  // Sources
  output logic                      sub_clk_o,
  output logic                      sec_one_o,
  output logic                      thr_zero_o,
  output logic                      thr_two_o,
  output logic                      in_pin_o,
  output logic                      dir_pin_o
);
  import rtec_pkg::*;
  logic [2:0] ph_r = 3'h0;
  wire        tick = ovf_en_i && ph_r == 3'h7;
  always_ff @(posedge clk_i) ph_r <= ph_r + 3'h1;
  // Sub clock free-runs, period of eight system clocks
  assign sub_clk_o  = ph_r[2];
  assign sec_one_o  = tick && ovf_sel_i == RTEC_EV_SECOND_ONE;
  assign thr_zero_o = tick && ovf_sel_i == RTEC_EV_THIRD_ZERO;
  assign thr_two_o  = tick && ovf_sel_i == RTEC_EV_THIRD_TWO;
  assign in_pin_o   = pin_mode_i[1] ? ph_r[2] : pin_mode_i[0];
  assign dir_pin_o  = dir_up_i;
endmodule

/* tb/rtec_timer_asserts.sv */
// Checker for the timer register port, output pin and interrupt request
`timescale 1ns/1ps
module rtec_timer_asserts
  import rtec_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              srst_i,
  input wire logic              ce_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [CNT_W-1:0]  wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [CNT_W-1:0]  rdata_o,
  // Sources and pins
  input wire logic              sub_clock_divided_source_i,
  input wire logic              second_group_timer_one_ovf_i,
  input wire logic              third_group_timer_zero_ovf_i,
  input wire logic              third_group_timer_two_ovf_i,
  input wire logic              timer_input_pin_i,
  input wire logic              timer_output_pin_i,
  input wire logic              timer_output_pin_o,
  input wire logic              timer_output_pin_oe_o,
  input wire logic              irq_o
);
  import rtec_pkg::*;
  logic          start_r;
  logic          held_r;
  logic [15:0]   shad_r;
  rtec_mode_type mode_r;
  wire           we = wr_i & ce_i;
  wire           re = rd_i & ce_i;
  ////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      start_r <= 1'b0;
      mode_r  <= rtec_mode_type'(RTEC_MODE_RST);
    end else if (we && addr_i == RTEC_ADDR_START) begin
      start_r <= wdata_i[RTEC_START_BIT];
    end else if (we && addr_i == RTEC_ADDR_MODE) begin
      mode_r  <= rtec_mode_type'(wdata_i[15:0]);
    end
  end
  // Shadow is trusted from reset, and once written while stopped, until a start
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      held_r <= 1'b1;
      shad_r <= RTEC_COUNT_RST;
    end else if (we && addr_i == RTEC_ADDR_COUNT && !start_r) begin
      held_r <= 1'b1;
      shad_r <= wdata_i[15:0];
    end else if (we && addr_i == RTEC_ADDR_START && wdata_i[0]) begin
      held_r <= 1'b0;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  rd_idle_a: assert property ($past(ce_i) && !$past(rd_i) |-> rdata_o == '0)
    else $error("read data not zero outside read slot");
  unmapped_rd_a: assert property ($past(re && addr_i > RTEC_ADDR_STATUS) |-> rdata_o == '0)
    else $error("unmapped read not zero");
  run_status_a: assert property ($past(re && addr_i == RTEC_ADDR_STATUS && !mode_r.gate_en)
    |-> rdata_o[RTEC_STAT_RUN] == $past(start_r)) else $error("run bit differs from start");
  timer_down_a: assert property ($past(re && addr_i == RTEC_ADDR_STATUS
    && mode_r.op_mode == RTEC_OP_TIMER) |-> !rdata_o[RTEC_STAT_DIRUP]) else $error("timer up");
  stop_hold_a: assert property ($past(re && addr_i == RTEC_ADDR_COUNT && held_r)
    |-> rdata_o == $past(shad_r)) else $error("stopped counter moved");
  pin_wrap_a: assert property ($past(ce_i) && $changed(timer_output_pin_o) |-> irq_o)
    else $error("output pin toggled without wrap");
  oe_pulse_a: assert property (timer_output_pin_oe_o
    |-> mode_r.pulse_out || $past(mode_r.pulse_out)) else $error("pin driven without pulse");
  irq_run_a: assert property (irq_o |-> $past(start_r) || $past(start_r, 2))
    else $error("interrupt while stopped");
endmodule

/* tb/testbench.sv */
// Testbench for the reloadable timer: register port, periods, pins
`timescale 1ns/1ps
module testbench;
  import rtec_pkg::*;
  logic        clk_i, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, ovf_en = 1'b1, dir_up = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic [1:0]  pin_mode = 2'h2;
  logic        sub, s1, t0, t2, in_pin, dir_pin, pin_o, oe_o, irq_o, pin_wire;
  rtec_ev_type ovf_sel = RTEC_EV_PIN;
  int          n_errors = 0, checks_done = 0;
  localparam logic [15:0] MODES [10] = '{16'h0040, 16'h0044, 16'h0048, 16'h004C,
    16'h0441, 16'h1441, 16'h0041, 16'h0141, 16'h0241, 16'h0341};
  localparam int PERS [10] = '{2, 16, 64, 16, 16, 16, 16, 16, 16, 16};
  // Wire level of the shared output pin
  assign pin_wire = oe_o ? pin_o : dir_pin;
  rtec_timer u_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sub_clock_divided_source_i(sub), .second_group_timer_one_ovf_i(s1),
    .third_group_timer_zero_ovf_i(t0), .third_group_timer_two_ovf_i(t2),
    .timer_input_pin_i(in_pin), .timer_output_pin_i(pin_wire), .timer_output_pin_o(pin_o),
    .timer_output_pin_oe_o(oe_o), .irq_o(irq_o));
  rtec_partner u_far (.clk_i(clk_i), .pin_mode_i(pin_mode), .ovf_en_i(ovf_en),
    .ovf_sel_i(ovf_sel), .dir_up_i(dir_up), .sub_clk_o(sub), .sec_one_o(s1),
    .thr_zero_o(t0), .thr_two_o(t2), .in_pin_o(in_pin), .dir_pin_o(dir_pin));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic finish_test;
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    chk("rdata", e, rdata_o & m);
  endtask
  task automatic wirq(output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (irq_o !== 1'b1 && n < 4000);
    if (n >= 4000) chk("irq", 16'h0001, 16'h0000);
  endtask
  // Spacing of two interrupts, and pin toggle when driven
  task automatic per(input int p);
    int   n;
    logic lv;
    wirq(n);
    lv = pin_o;
    wirq(n);
    chk("period", p[15:0], n[15:0]);
    if (oe_o === 1'b1) chk("pin", {15'h0, ~lv}, {15'h0, pin_o});
  endtask
  ////////////////////////////////////////
  task automatic t_stop;
    wr(RTEC_ADDR_COUNT, 16'h0007);
    rd(RTEC_ADDR_COUNT, 16'hFFFF, 16'h0007);
    repeat (20) @(posedge clk_i);
    rd(RTEC_ADDR_COUNT, 16'hFFFF, 16'h0007);
    rd(RTEC_ADDR_STATUS, 16'h0005, 16'h0000);
    rd(4'h9, 16'hFFFF, 16'h0000);
  endtask
  task automatic t_table;
    for (int i = 0; i < 10; i++) begin
      wr(RTEC_ADDR_MODE, MODES[i]);
      ovf_sel <= rtec_ev_type'(MODES[i][9:8]);
      wr(RTEC_ADDR_COUNT, (i == 5) ? 16'hFFFE : 16'h0001);
      wr(RTEC_ADDR_START, 16'h0001);
      per(PERS[i]);
      wr(RTEC_ADDR_START, 16'h0000);
    end
  endtask
  task automatic t_reload;
    wr(RTEC_ADDR_MODE, 16'h0040);
    wr(RTEC_ADDR_COUNT, 16'h0001);
    wr(RTEC_ADDR_START, 16'h0001);
    per(2);
    wr(RTEC_ADDR_COUNT, 16'h0004);
    repeat (2) @(posedge clk_i);
    per(5);
    rd(RTEC_ADDR_STATUS, 16'h0001, 16'h0001);
    wr(RTEC_ADDR_START, 16'h0000);
  endtask
  task automatic t_gate;
    wr(RTEC_ADDR_MODE, 16'h0030);
    pin_mode <= 2'h0;
    wr(RTEC_ADDR_COUNT, 16'h0003);
    wr(RTEC_ADDR_START, 16'h0001);
    repeat (30) @(posedge clk_i);
    rd(RTEC_ADDR_COUNT, 16'hFFFF, 16'h0003);
    @(posedge clk_i);
    pin_mode <= 2'h1;
    per(4);
    wr(RTEC_ADDR_START, 16'h0000);
  endtask
  task automatic t_free;
    int n;
    ovf_sel <= RTEC_EV_SECOND_ONE;
    for (int f = 0; f < 2; f++) begin
      wr(RTEC_ADDR_COUNT, 16'hFFFE);
      wr(RTEC_ADDR_MODE, (f == 1) ? 16'h1181 : 16'h1101);
      wr(RTEC_ADDR_START, 16'h0001);
      wirq(n);
      @(posedge clk_i);
      ovf_en <= 1'b0;
      rd(RTEC_ADDR_COUNT, 16'hFFFF, (f == 1) ? 16'h0000 : 16'hFFFE);
      wr(RTEC_ADDR_START, 16'h0000);
      ovf_en <= 1'b1;
    end
  endtask
  task automatic t_dir;
    wr(RTEC_ADDR_MODE, 16'h0801);
    dir_up <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(RTEC_ADDR_STATUS, 16'h0004, 16'h0004);
    chk("oe", 16'h0000, {15'h0, oe_o});
    @(posedge clk_i);
    dir_up <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(RTEC_ADDR_STATUS, 16'h0004, 16'h0000);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    t_stop;
    t_table;
    t_reload;
    t_gate;
    t_free;
    t_dir;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    finish_test;
  end
endmodule
bind rtec_timer rtec_timer_asserts #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_chk (.clk_i, .srst_i,
  .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sub_clock_divided_source_i,
  .second_group_timer_one_ovf_i, .third_group_timer_zero_ovf_i, .third_group_timer_two_ovf_i,
  .timer_input_pin_i, .timer_output_pin_i, .timer_output_pin_o, .timer_output_pin_oe_o, .irq_o);
